// ### design/link_regs_pkg.sv
// constants shared by the link register bank and its helpers
package link_regs_pkg;
   // register offsets (byte addresses on the local register port)
   localparam logic [7:0]  OFF_CHAN_SELECT  = 8'h60;
   localparam logic [7:0]  OFF_CHAN_CONFIG  = 8'h64;
   localparam logic [7:0]  OFF_PTR_SELECT   = 8'h68;
   localparam logic [7:0]  OFF_PTR_ADDRESS  = 8'h6c;
   localparam logic [7:0]  OFF_LANE_MASK    = 8'h70;
   localparam logic [7:0]  OFF_SPARE_TWO    = 8'h74;
   localparam logic [7:0]  OFF_SPARE_THREE  = 8'h78;
   localparam logic [7:0]  OFF_LANE_POWER   = 8'h7c;
   localparam logic [7:0]  OFF_REMOTE_BASE  = 8'h80;

   // sizes
   localparam int          NUM_CHAN         = 64;
   localparam int          NUM_PTR          = 8;
   localparam int          CHAN_SEL_W       = 8;
   localparam int          PTR_SEL_W        = 4;

   // channel configuration word fields
   localparam int          CFG_ENABLE_BIT   = 31;
   localparam int          CFG_PULSE_BIT    = 30;
   localparam int          CFG_LOW_BIT      = 29;
   localparam int          CFG_SECURE_BIT   = 28;
   localparam int          CFG_SWEN_BIT     = 27;
   localparam int          CFG_DNID_LSB     = 16;
   localparam int          CFG_MPS_LSB      = 8;
   localparam int          CFG_VEC_LSB      = 0;
   localparam logic [31:0] CFG_WR_MASK      = 32'hf803_0f1f;
   localparam logic [31:0] CFG_RST          = 32'h0000_0000;

   // pointer table
   localparam logic [31:0] PTR_WR_MASK      = 32'hffff_fffc;
   localparam logic [31:0] PTR_RST          = 32'h0000_0000;

   // lane mask counts
   localparam int          SLEEP_CNT_LSB    = 24;
   localparam int          DISABLE_CNT_LSB  = 16;
   localparam logic [31:0] LANE_MASK_WR     = 32'hffff_0000;
   localparam logic [31:0] LANE_MASK_RST    = 32'h092e_0000;
   localparam int          MASK_SYMBOLS     = 16;

   // spare and power/test registers
   localparam logic [31:0] SPARE_WR_MASK    = 32'hffff_0000;
   localparam logic [31:0] SPARE_RST        = 32'h0000_0000;
   localparam logic [31:0] POWER_WR_MASK    = 32'hffff_0000;
   localparam logic [31:0] POWER_RST        = 32'h0000_0000;
   localparam int          QUICK_BIT        = 31;
   localparam int          TX_SPC_LSB       = 18;
   localparam int          RX_SPC_LSB       = 16;
   localparam logic [1:0]  SPC_FAST_SLEEP   = 2'h0;
   localparam logic [1:0]  SPC_FULL_SLEEP   = 2'h1;

   // wake-up prescaler lengths in clocks
   localparam int          WAKE_PRESCALE_FULL  = 65536;
   localparam int          WAKE_PRESCALE_QUICK = 256;
endpackage

// ### design/chan_cfg_mem.sv
// channel configuration store: one write port, two registered read ports
`timescale 1ns/1ps
`default_nettype none
module chan_cfg_mem (
   input  wire logic        clk,
   input  wire logic        wr_en,
   input  wire logic [5:0]  wr_addr,
   input  wire logic [31:0] wr_data,
   input  wire logic [5:0]  rd_a_addr,
   output logic      [31:0] rd_a_data,
   input  wire logic [5:0]  rd_b_addr,
   output logic      [31:0] rd_b_data
);
   logic [31:0] mem [link_regs_pkg::NUM_CHAN];

   // no reset on the array; the top clears it word by word after reset
   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_addr] <= wr_data;
      end
      rd_a_data <= mem[rd_a_addr];
      rd_b_data <= mem[rd_b_addr];
   end
endmodule
`default_nettype wire

// ### design/lane_mask_timer.sv
// receive mask timer: hides lane data for count x 16 symbol times
`timescale 1ns/1ps
`default_nettype none
module lane_mask_timer (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       symbol_en,
   input  wire logic       enter_sleep,
   input  wire logic       enter_disable,
   input  wire logic [7:0] sleep_cnt,
   input  wire logic [7:0] disable_cnt,
   output logic            rx_mask
);
   logic [11:0] remain_q;
   logic [11:0] remain_d;
   logic [11:0] load_sleep;
   logic [11:0] load_disable;

   assign load_sleep   = 12'(sleep_cnt * link_regs_pkg::MASK_SYMBOLS);
   assign load_disable = 12'(disable_cnt * link_regs_pkg::MASK_SYMBOLS);

   // a new lane state restarts the window; a zero count gives no mask
   always_comb begin
      remain_d = remain_q;
      if (enter_disable) begin
         remain_d = load_disable;
      end else if (enter_sleep) begin
         remain_d = load_sleep;
      end else if (symbol_en && remain_q != 12'h000) begin
         remain_d = remain_q - 12'h001;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         remain_q <= 12'h000;
      end else begin
         remain_q <= remain_d;
      end
   end

   assign rx_mask = (remain_q != 12'h000);
endmodule
`default_nettype wire

// ### design/link_irq_map_serdes_ctl_regs.sv
// link controller register bank: channel map, pointer table, lane controls
`timescale 1ns/1ps
`default_nettype none
module link_irq_map_serdes_ctl_regs #(
   parameter int WAKE_PRESCALE = link_regs_pkg::WAKE_PRESCALE_FULL
) (
   input  wire logic        clk,
   input  wire logic        arst_n,
   // local register port
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   output logic      [31:0] reg_rdata,
   output logic             reg_rvalid,
   output logic             reg_busy,
   // remote register window
   output logic             rmt_req,
   output logic             rmt_write,
   output logic      [7:0]  rmt_addr,
   output logic      [31:0] rmt_wdata,
   input  wire logic        rmt_ack,
   input  wire logic [31:0] rmt_rdata,
   // interrupt inputs and software requests
   input  wire logic [63:0] irq_in,
   input  wire logic        sw_irq_req,
   input  wire logic [7:0]  sw_irq_chan,
   input  wire logic        sw_irq_secure,
   input  wire logic        route_to_here,
   input  wire logic        route_to_config,
   // outgoing interrupt packet
   output logic             out_valid,
   input  wire logic        out_ready,
   output logic      [3:0]  out_mps,
   output logic      [4:0]  out_vector,
   output logic             local_set_valid,
   output logic      [4:0]  local_set_vector,
   // received interrupt packet and set-register write
   input  wire logic        rx_valid,
   output logic             rx_ready,
   input  wire logic [3:0]  rx_mps,
   input  wire logic [4:0]  rx_vector,
   output logic             set_valid,
   input  wire logic        set_ready,
   output logic      [31:0] set_addr,
   output logic      [31:0] set_data,
   output logic             set_internal,
   // lane controls
   input  wire logic        symbol_en,
   input  wire logic        lane_enter_sleep,
   input  wire logic        lane_enter_disable,
   output logic             rx_mask,
   output logic             wake_tick,
   output logic      [1:0]  tx_spc,
   output logic      [1:0]  rx_spc,
   output logic             tx_sleep_on,
   output logic             rx_sleep_on,
   output logic             tx_sleep_full,
   output logic             rx_sleep_full
);
   typedef enum logic [1:0] {RMT_IDLE, RMT_WAIT} rmt_state_e;
   typedef enum logic [1:0] {DSP_CLEAR, DSP_IDLE, DSP_FETCH, DSP_SEND} dsp_state_e;

   // lowest pending channel, with a found flag in the top bit
   function automatic logic [6:0] first_set(input logic [63:0] v);
      logic [6:0] r;
      r = 7'h00;
      for (int i = 63; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 6'(i)};
         end
      end
      return r;
   endfunction

   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                         input logic [31:0] mask);
      return (old & ~mask) | (wd & mask);
   endfunction

   logic [7:0]  chan_sel_q;
   logic [3:0]  ptr_sel_q;
   logic [31:0] ptr_q [link_regs_pkg::NUM_PTR];
   logic [31:0] lane_mask_q, spare2_q, spare3_q, power_q;
   logic [63:0] en_q, pulse_q, low_q, sec_q, swen_q;
   logic [63:0] prev_q, armed_q, pend_q;
   logic [31:0] rdata_q;
   logic        rvalid_q;
   rmt_state_e  rmt_q;
   logic        rmt_write_q;
   logic [7:0]  rmt_addr_q;
   logic [31:0] rmt_wdata_q;
   dsp_state_e  dsp_q;
   logic [5:0]  pick_q;
   logic [5:0]  clr_idx_q;
   logic [15:0] wake_cnt_q;
   logic        wake_q;
   logic        set_valid_q, set_internal_q;
   logic [31:0] set_addr_q, set_data_q;
   logic [31:0] cfg_rd_a, cfg_rd_b;

   // access decode; remote window takes every offset from 0x80 up
   wire is_remote  = reg_addr >= link_regs_pkg::OFF_REMOTE_BASE;
   wire accept     = (rmt_q == RMT_IDLE) && (reg_wr || reg_rd);
   wire wr_local   = accept && reg_wr && !is_remote;
   wire chan_ok    = chan_sel_q < 8'(link_regs_pkg::NUM_CHAN);
   wire ptr_ok     = ptr_sel_q < 4'(link_regs_pkg::NUM_PTR);
   wire [2:0] ptr_i = ptr_sel_q[2:0];
   wire [5:0] chan_i = chan_sel_q[5:0];
   wire wr_cfg     = wr_local && reg_addr == link_regs_pkg::OFF_CHAN_CONFIG && chan_ok;
   wire [31:0] cfg_wr_word = reg_wdata & link_regs_pkg::CFG_WR_MASK;

   // read mux; undecoded and reserved positions return zero
   wire [31:0] rd_mux =
      (reg_addr == link_regs_pkg::OFF_CHAN_SELECT) ? {24'h000000, chan_sel_q} :
      (reg_addr == link_regs_pkg::OFF_CHAN_CONFIG) ? (chan_ok ? cfg_rd_a : 32'h0000_0000) :
      (reg_addr == link_regs_pkg::OFF_PTR_SELECT)  ? {28'h0000000, ptr_sel_q} :
      (reg_addr == link_regs_pkg::OFF_PTR_ADDRESS) ? (ptr_ok ? ptr_q[ptr_i] : 32'h0000_0000) :
      (reg_addr == link_regs_pkg::OFF_LANE_MASK)   ? lane_mask_q :
      (reg_addr == link_regs_pkg::OFF_SPARE_TWO)   ? spare2_q :
      (reg_addr == link_regs_pkg::OFF_SPARE_THREE) ? spare3_q :
      (reg_addr == link_regs_pkg::OFF_LANE_POWER)  ? power_q : 32'h0000_0000;

   // index and plain storage registers
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         chan_sel_q  <= 8'h00;
         ptr_sel_q   <= 4'h0;
         lane_mask_q <= link_regs_pkg::LANE_MASK_RST;
         spare2_q    <= link_regs_pkg::SPARE_RST;
         spare3_q    <= link_regs_pkg::SPARE_RST;
         power_q     <= link_regs_pkg::POWER_RST;
         for (int i = 0; i < link_regs_pkg::NUM_PTR; i++) begin
            ptr_q[i] <= link_regs_pkg::PTR_RST;
         end
      end else if (wr_local) begin
         case (reg_addr)
            link_regs_pkg::OFF_CHAN_SELECT: chan_sel_q <= reg_wdata[7:0];
            link_regs_pkg::OFF_PTR_SELECT:  ptr_sel_q <= reg_wdata[3:0];
            link_regs_pkg::OFF_PTR_ADDRESS: begin
               if (ptr_ok) begin
                  ptr_q[ptr_i] <= reg_wdata & link_regs_pkg::PTR_WR_MASK;
               end
            end
            link_regs_pkg::OFF_LANE_MASK:
               lane_mask_q <= merge(lane_mask_q, reg_wdata, link_regs_pkg::LANE_MASK_WR);
            link_regs_pkg::OFF_SPARE_TWO:
               spare2_q <= merge(spare2_q, reg_wdata, link_regs_pkg::SPARE_WR_MASK);
            link_regs_pkg::OFF_SPARE_THREE:
               spare3_q <= merge(spare3_q, reg_wdata, link_regs_pkg::SPARE_WR_MASK);
            link_regs_pkg::OFF_LANE_POWER:
               power_q <= merge(power_q, reg_wdata, link_regs_pkg::POWER_WR_MASK);
            default: ;
         endcase
      end
   end

   // per-channel control bits kept in flops so all 64 inputs are watched at once
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         en_q    <= 64'h0;
         pulse_q <= 64'h0;
         low_q   <= 64'h0;
         sec_q   <= 64'h0;
         swen_q  <= 64'h0;
      end else if (wr_cfg) begin
         en_q[chan_i]    <= reg_wdata[link_regs_pkg::CFG_ENABLE_BIT];
         pulse_q[chan_i] <= reg_wdata[link_regs_pkg::CFG_PULSE_BIT];
         low_q[chan_i]   <= reg_wdata[link_regs_pkg::CFG_LOW_BIT];
         sec_q[chan_i]   <= reg_wdata[link_regs_pkg::CFG_SECURE_BIT];
         swen_q[chan_i]  <= reg_wdata[link_regs_pkg::CFG_SWEN_BIT];
      end
   end

   // read answer one cycle after a local read; remote reads wait for the ack
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q  <= 32'h0000_0000;
         rvalid_q <= 1'b0;
      end else begin
         rvalid_q <= 1'b0;
         if (accept && reg_rd && !is_remote) begin
            rdata_q  <= rd_mux;
            rvalid_q <= 1'b1;
         end else if (rmt_q == RMT_WAIT && rmt_ack && !rmt_write_q) begin
            rdata_q  <= rmt_rdata;
            rvalid_q <= 1'b1;
         end
      end
   end

   // remote window: the access is passed on with 0x80 taken off the address and the port stalls meanwhile
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rmt_q       <= RMT_IDLE;
         rmt_write_q <= 1'b0;
         rmt_addr_q  <= 8'h00;
         rmt_wdata_q <= 32'h0000_0000;
      end else begin
         case (rmt_q)
            RMT_IDLE: begin
               if (accept && is_remote) begin
                  rmt_q       <= RMT_WAIT;
                  rmt_write_q <= reg_wr;
                  rmt_addr_q  <= reg_addr - link_regs_pkg::OFF_REMOTE_BASE;
                  rmt_wdata_q <= reg_wdata;
               end
            end
            RMT_WAIT: if (rmt_ack) rmt_q <= RMT_IDLE;
            default:  rmt_q <= RMT_IDLE;
         endcase
      end
   end

   // detection: polarity first, then edge or level
   wire [63:0] act     = irq_in ^ low_q;
   wire [63:0] hw_evt  = en_q & ((pulse_q & act & ~prev_q) |
                                 (~pulse_q & act & ~armed_q));
   wire        sw_ok   = sw_irq_req && sw_irq_chan < 8'(link_regs_pkg::NUM_CHAN) &&
                         swen_q[sw_irq_chan[5:0]] &&
                         (sw_irq_secure || !sec_q[sw_irq_chan[5:0]]);
   wire [63:0] sw_evt  = sw_ok ? (64'h1 << sw_irq_chan[5:0]) : 64'h0;
   wire [6:0]  next    = first_set(pend_q);
   wire        take    = (dsp_q == DSP_IDLE) && next[6];
   wire [63:0] take_1h = take ? (64'h1 << next[5:0]) : 64'h0;

   // a new event beats the clear of the bit being dispatched
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         prev_q  <= 64'h0;
         armed_q <= 64'h0;
         pend_q  <= 64'h0;
      end else begin
         prev_q  <= act;
         armed_q <= (armed_q | (hw_evt & ~pulse_q)) & act; // one event per level assertion
         pend_q  <= (pend_q & ~take_1h) | hw_evt | sw_evt;
      end
   end

   // dispatcher; after reset it first walks the store to clear every word
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         dsp_q     <= DSP_CLEAR;
         pick_q    <= 6'h00;
         clr_idx_q <= 6'h00;
      end else begin
         case (dsp_q)
            DSP_CLEAR: begin
               clr_idx_q <= clr_idx_q + 6'h01;
               if (clr_idx_q == 6'h3f) dsp_q <= DSP_IDLE;
            end
            DSP_IDLE: begin
               if (take) begin
                  pick_q <= next[5:0];
                  dsp_q  <= DSP_FETCH;
               end
            end
            DSP_FETCH: dsp_q <= DSP_SEND;
            DSP_SEND: begin
               if (route_to_here || out_ready) dsp_q <= DSP_IDLE;
            end
            default: dsp_q <= DSP_IDLE;
         endcase
      end
   end

   wire mem_clear = (dsp_q == DSP_CLEAR);

   chan_cfg_mem u_cfg (
      .clk       (clk),
      .wr_en     (wr_cfg || mem_clear),
      .wr_addr   (mem_clear ? clr_idx_q : chan_i),
      .wr_data   (mem_clear ? link_regs_pkg::CFG_RST : cfg_wr_word),
      .rd_a_addr (chan_i),
      .rd_a_data (cfg_rd_a),
      .rd_b_addr (pick_q),
      .rd_b_data (cfg_rd_b)
   );

   // outgoing packet or local pending set, fields straight from the store
   assign out_valid        = (dsp_q == DSP_SEND) && !route_to_here;
   assign local_set_valid  = (dsp_q == DSP_SEND) && route_to_here;
   assign out_mps          = cfg_rd_b[link_regs_pkg::CFG_MPS_LSB +: 4];
   assign out_vector       = cfg_rd_b[link_regs_pkg::CFG_VEC_LSB +: 5];
   assign local_set_vector = cfg_rd_b[link_regs_pkg::CFG_VEC_LSB +: 5];

   // received packets: pointer lookup, at most one set-register write per packet
   assign rx_ready = !set_valid_q || set_ready;
   wire   rx_take  = rx_valid && rx_ready;
   wire   rx_hit   = rx_mps < 4'(link_regs_pkg::NUM_PTR);
   wire [31:0] ptr_hit = ptr_q[rx_mps[2:0]];

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         set_valid_q    <= 1'b0;
         set_addr_q     <= 32'h0000_0000;
         set_data_q     <= 32'h0000_0000;
         set_internal_q <= 1'b0;
      end else if (rx_take) begin
         set_valid_q    <= rx_hit;                  // unmatched selects are dropped
         set_addr_q     <= route_to_config ? {24'h000000, ptr_hit[7:0]} : ptr_hit;
         set_data_q     <= 32'h0000_0001 << rx_vector;
         set_internal_q <= route_to_config;
      end else if (set_ready) begin
         set_valid_q <= 1'b0;
      end
   end

   assign set_valid    = set_valid_q;
   assign set_addr     = set_addr_q;
   assign set_data     = set_data_q;
   assign set_internal = set_internal_q;

   // wake-up prescaler; quick mode trades realism for short test runs
   wire        quick    = power_q[link_regs_pkg::QUICK_BIT];
   wire [15:0] wake_end = quick ? 16'(link_regs_pkg::WAKE_PRESCALE_QUICK - 1)
                                : 16'(WAKE_PRESCALE - 1);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         wake_cnt_q <= 16'h0000;
         wake_q     <= 1'b0;
      end else begin
         wake_q     <= (wake_cnt_q >= wake_end);
         wake_cnt_q <= (wake_cnt_q >= wake_end) ? 16'h0000 : wake_cnt_q + 16'h0001;
      end
   end
   assign wake_tick = wake_q;

   lane_mask_timer u_mask (
      .clk           (clk),
      .arst_n        (arst_n),
      .symbol_en     (symbol_en),
      .enter_sleep   (lane_enter_sleep),
      .enter_disable (lane_enter_disable),
      .sleep_cnt     (lane_mask_q[link_regs_pkg::SLEEP_CNT_LSB +: 8]),
      .disable_cnt   (lane_mask_q[link_regs_pkg::DISABLE_CNT_LSB +: 8]),
      .rx_mask       (rx_mask)
   );

   // power control decode: bit 1 set disables sleep entirely
   assign tx_spc        = power_q[link_regs_pkg::TX_SPC_LSB +: 2];
   assign rx_spc        = power_q[link_regs_pkg::RX_SPC_LSB +: 2];
   assign tx_sleep_on   = !tx_spc[1];
   assign rx_sleep_on   = !rx_spc[1];
   assign tx_sleep_full = (tx_spc == link_regs_pkg::SPC_FULL_SLEEP);
   assign rx_sleep_full = (rx_spc == link_regs_pkg::SPC_FULL_SLEEP);

   // register port outputs
   assign reg_rdata  = rdata_q;
   assign reg_rvalid = rvalid_q;
   assign reg_busy   = (rmt_q != RMT_IDLE);
   assign rmt_req    = (rmt_q == RMT_WAIT);
   assign rmt_write  = rmt_write_q;
   assign rmt_addr   = rmt_addr_q;
   assign rmt_wdata  = rmt_wdata_q;
endmodule
`default_nettype wire

// ### sim/link_regs_chk.sv
// port assertions for the link register bank
`timescale 1ns/1ps
`default_nettype none
module link_regs_chk (
   input wire logic        clk,
   input wire logic        arst_n,
   input wire logic        reg_rd,
   input wire logic        reg_busy,
   input wire logic [7:0]  reg_addr,
   input wire logic        reg_rvalid,
   input wire logic        rmt_req,
   input wire logic        rmt_ack,
   input wire logic [7:0]  rmt_addr,
   input wire logic        rx_valid,
   input wire logic        rx_ready,
   input wire logic [3:0]  rx_mps,
   input wire logic        set_valid,
   input wire logic        set_ready,
   input wire logic [31:0] set_addr,
   input wire logic [31:0] set_data,
   input wire logic [1:0]  tx_spc,
   input wire logic        tx_sleep_on,
   input wire logic        tx_sleep_full
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // window reads go out with the base stripped off, local reads answer on the next cycle
   property win_p;
      reg_rd && !reg_busy && reg_addr[7] |=> rmt_req && rmt_addr == $past(reg_addr) - 8'h80;
   endproperty
   rmt_start_a: assert property (win_p)
      else $error("remote access not started");
   rmt_hold_a: assert property (rmt_req && !rmt_ack |=> rmt_req)
      else $error("remote request dropped early");
   rd_answer_a: assert property (reg_rd && !reg_busy && !reg_addr[7] |=> reg_rvalid)
      else $error("local read not answered");
   // received packets: entries 0 to 7 only, held until taken, one bit set
   set_start_a: assert property (rx_valid && rx_ready && !rx_mps[3] |=> set_valid)
      else $error("set write missing");
   set_drop_a: assert property (rx_valid && !set_valid && rx_mps[3] |=> !set_valid)
      else $error("bad select not dropped");
   set_hold_a: assert property (set_valid && !set_ready |=> set_valid && $stable(set_addr))
      else $error("set write not held");
   set_onehot_a: assert property (set_valid |-> $onehot(set_data))
      else $error("set data not one hot");
   spc_decode_a: assert property (tx_sleep_on == !tx_spc[1] && tx_sleep_full == (tx_spc == 2'h1))
      else $error("power field decode wrong");
   cover property (rmt_req && rmt_ack);
   cover property (set_valid && set_ready);
   cover property (rx_valid && rx_mps[3]);
endmodule
bind link_irq_map_serdes_ctl_regs link_regs_chk link_regs_chk_inst (.*);
`default_nettype wire

// ### sim/remote_regs_model.sv
// remote register copy answering the forwarded window accesses
`timescale 1ns/1ps
`default_nettype none
module remote_regs_model (
   input  wire logic        clk,
   input  wire logic        slow,
   input  wire logic        rmt_req,
   input  wire logic        rmt_write,
   input  wire logic [7:0]  rmt_addr,
   input  wire logic [31:0] rmt_wdata,
   output logic             rmt_ack,
   output logic      [31:0] rmt_rdata
);
   logic [31:0] mem_q [32];
   int          wait_q = 0;
   initial begin
      rmt_ack = 1'b0;
      rmt_rdata = 32'h0;
   end
   // answers at once or after six idle cycles; read data toggles when stale
   always @(posedge clk) begin
      rmt_ack <= 1'b0;
      rmt_rdata <= ~rmt_rdata;
      wait_q <= (rmt_req && !rmt_ack) ? wait_q + 1 : 0;
      if (rmt_req && !rmt_ack && wait_q >= (slow ? 6 : 0)) begin
         rmt_ack <= 1'b1;
         if (rmt_write) mem_q[rmt_addr[6:2]] <= rmt_wdata;
         else rmt_rdata <= mem_q[rmt_addr[6:2]];
      end
   end
endmodule
`default_nettype wire

// ### sim/link_irq_map_serdes_ctl_regs_tb_top.sv
// self-checking bench for the link register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin errors++; $display("wrong value at %0t: %h, expected %h", $time, a, e); end end
module link_irq_map_serdes_ctl_regs_tb_top;
   localparam int PRESCALE = 512;
   logic        clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, slow = 1'b0;
   logic        sw_irq_req = 1'b0, sw_irq_secure = 1'b0, route_to_here = 1'b0;
   logic        route_to_config = 1'b0, out_ready = 1'b0, rx_valid = 1'b0, set_ready = 1'b0;
   logic        symbol_en = 1'b1, lane_enter_sleep = 1'b0, lane_enter_disable = 1'b0;
   logic [7:0]  reg_addr = 8'h0, sw_irq_chan = 8'h0, rmt_addr;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, rmt_wdata, rmt_rdata, set_addr, set_data;
   logic [63:0] irq_in = 64'h0;
   logic [3:0]  rx_mps = 4'h0, out_mps;
   logic [4:0]  rx_vector = 5'h4, out_vector, local_set_vector;
   logic [1:0]  tx_spc, rx_spc;
   logic        reg_rvalid, reg_busy, rmt_req, rmt_write, rmt_ack, out_valid, local_set_valid;
   logic        rx_ready, set_valid, set_internal, rx_mask, wake_tick, tx_sleep_on, rx_sleep_on;
   logic        tx_sleep_full, rx_sleep_full;
   int          errors = 0, comparisons = 0, i;
   link_irq_map_serdes_ctl_regs #(.WAKE_PRESCALE(PRESCALE)) link_irq_map_serdes_ctl_regs_inst (.*);
   remote_regs_model remote_regs_model_inst (.*);
   always #20 clk = ~clk;
   // all drivers move on the falling edge; writes wait out a busy window
   task wr(input logic [7:0] a, input logic [31:0] d);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk) reg_wr = 1'b0;
      repeat (20) if (reg_busy !== 1'b0) @(negedge clk);
      @(negedge clk);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      reg_rd = 1'b1;
      reg_addr = a;
      @(negedge clk) reg_rd = 1'b0;
      repeat (20) if (reg_rvalid !== 1'b1) @(negedge clk);
      `CHK(reg_rvalid, 1'b1)
      `CHK(reg_rdata, e)
      @(negedge clk);
   endtask
   // dispatch answer; the far side stalls one cycle before taking it
   task irq_out(input logic loc, input logic [8:0] e);
      repeat (20) if ((loc ? local_set_valid : out_valid) !== 1'b1) @(negedge clk);
      `CHK(loc ? local_set_valid : out_valid, 1'b1)
      `CHK(loc ? {4'h0, local_set_vector} : {out_mps, out_vector}, e)
      @(negedge clk) out_ready = 1'b1;
      @(negedge clk) out_ready = 1'b0;
   endtask
   task rxp(input logic [3:0] m, input logic [31:0] ea);
      rx_valid = 1'b1;
      rx_mps = m;
      @(negedge clk) rx_valid = 1'b0;
      `CHK(set_valid, !m[3])
      if (set_valid === 1'b1) `CHK({set_internal, set_addr, set_data}, {route_to_config, ea, 32'h10})
      @(negedge clk) set_ready = 1'b1;
      @(negedge clk) set_ready = 1'b0;
   endtask
   // software request on the selected channel; a taken one shows locally three edges later
   task swi(input logic s, input logic e);
      sw_irq_secure = s;
      sw_irq_req = 1'b1;
      @(negedge clk) sw_irq_req = 1'b0;
      repeat (2) @(negedge clk);
      `CHK(local_set_valid, e)
   endtask
   task lanes(input logic dis, input int e);
      int n;
      n = 0;
      lane_enter_sleep = !dis;
      lane_enter_disable = dis;
      @(negedge clk) lane_enter_sleep = 1'b0;
      lane_enter_disable = 1'b0;
      repeat (60) begin
         n += int'(rx_mask === 1'b1);
         @(negedge clk);
      end
      `CHK(n, e)
   endtask
   // the first tick may belong to the old period, so the second one is timed
   task per(input int e);
      int n;
      repeat (2) begin
         n = 0;
         do begin
            @(negedge clk);
            n++;
         end while (wake_tick !== 1'b1 && n < 1000);
      end
      `CHK(n, e)
   endtask
   task report_and_stop;
      $display("errors %0d comparisons %0d", errors, comparisons);
      if (errors == 0 && comparisons > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (10) @(negedge clk);
      arst_n = 1'b1;
      for (i = 0; i < 6; i++) rd(8'h68 + 8'(4 * i), i == 2 ? 32'h092e_0000 : 32'h0);
      for (i = 0; i < 4; i++) begin
         wr(8'h70 + 8'(4 * i), 32'hffff_ffff);
         rd(8'h70 + 8'(4 * i), 32'hffff_0000);
      end
      for (i = 0; i < 4; i++) begin
         wr(8'h7c, 32'(32'h5_0000 * i));
         `CHK({rx_sleep_on, rx_sleep_full}, {i < 2, i == 1})
      end
      per(PRESCALE);
      wr(8'h7c, 32'h8000_0000);
      per(256);
      wr(8'h70, 32'h0200_0000);
      lanes(1'b0, 32);
      lanes(1'b1, 0);
      wr(8'h68, 32'h2);
      wr(8'h6c, 32'h1234_567f);
      rd(8'h6c, 32'h1234_567c);
      rxp(4'h2, 32'h1234_567c);
      route_to_config = 1'b1;
      rxp(4'h2, 32'h0000_007c);
      rxp(4'h9, 32'h0);
      wr(8'h60, 32'h5);
      wr(8'h64, 32'h7fff_ffff);
      rd(8'h64, 32'h7803_0f1f);
      wr(8'h60, 32'h40);
      wr(8'h64, 32'hffff_ffff);
      rd(8'h64, 32'h0);
      wr(8'h60, 32'h5);
      wr(8'h64, 32'h8000_0307);
      irq_in[5] = 1'b1;
      irq_out(1'b0, 9'h067);
      repeat (4) @(negedge clk);
      `CHK(out_valid, 1'b0)
      route_to_here = 1'b1;
      wr(8'h64, 32'ha000_0307);
      irq_in[5] = 1'b0;
      irq_out(1'b1, 9'h007);
      wr(8'h64, 32'h1000_0307);
      sw_irq_chan = 8'h05;
      swi(1'b1, 1'b0);
      wr(8'h64, 32'h1800_0307);
      swi(1'b0, 1'b0);
      swi(1'b1, 1'b1);
      wr(8'h88, 32'hcafe_0123);
      slow = 1'b1;
      rd(8'h88, 32'hcafe_0123);
      report_and_stop;
   end
   initial begin
      #(40 * 20000);
      errors++;
      report_and_stop;
   end
endmodule
`default_nettype wire
